//--- hdl/ov_stage_defs.svh
// Constants for the overvoltage stage timing block.
`ifndef OV_STAGE_DEFS_SVH
`define OV_STAGE_DEFS_SVH
`define CLK_PERIOD_NS      8
`define PROG_CYCLE_NS      5000000
`define RESET_RATIO_PCT    14'd97
`define RATIO_SCALE        32'd100
`define Q16_ONE            32'h00010000
`define MAX_OP_UNITS       19'h57e40
`define FIXED_DELAY_DEF    18'h00008
`define TIME_DIAL_DEF      13'h0005
`define EXPONENT_DEF       12'h064
`define RELEASE_DELAY_DEF  15'h000c
`define PRIMARY_DIV        34'h0000003e8
`define EXP_INT_MAX        16'h000e
`endif

//--- hdl/ov_stage_pkg.sv
// Types for the overvoltage stage timing block.
package ov_stage_pkg;
  typedef enum logic [2:0] {
    NODE_ON           = 3'b000,
    NODE_BLOCKED      = 3'b001,
    NODE_TEST         = 3'b010,
    NODE_TEST_BLOCKED = 3'b011,
    NODE_OFF          = 3'b100
  } node_mode_e;

  typedef enum logic [1:0] {
    CALC_IDLE  = 2'b00,
    CALC_RATIO = 2'b01,
    CALC_POWER = 2'b10,
    CALC_INV   = 2'b11
  } calc_state_e;

  typedef struct packed {
    logic        inverse_delay_mode;
    logic [17:0] fixed_delay;
    logic [12:0] time_dial;
    logic [11:0] exponent;
    logic [14:0] release_delay;
    logic        delayed_release;
    logic        reset_after_release;
    logic        continue_in_release;
  } timing_cfg_s;

  typedef struct packed {
    logic start;
    logic trip;
    logic blocked;
  } stage_flags_s;
endpackage

//--- hdl/seq_divider.sv
// Restoring unsigned divider, one quotient bit per clock.
`timescale 1ns/1ps
module seq_divider (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic [31:0] numer,
  input  wire logic [31:0] denom,
  output logic             done,
  output logic [31:0]      quot
);
  logic [31:0] rem_reg;
  logic [31:0] q_reg;
  logic [31:0] d_reg;
  logic [5:0]  cnt_reg;
  logic        busy_reg;
  logic [32:0] trial;

  assign trial = {rem_reg, q_reg[31]} - {1'b0, d_reg};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
      cnt_reg  <= 6'h00;
      rem_reg  <= 32'h00000000;
      q_reg    <= 32'h00000000;
      d_reg    <= 32'h00000000;
      done     <= 1'b0;
      quot     <= 32'h00000000;
    end else begin
      done <= 1'b0;
      if (start && !busy_reg) begin
        busy_reg <= 1'b1;
        cnt_reg  <= 6'h20;
        rem_reg  <= 32'h00000000;
        q_reg    <= numer;
        d_reg    <= denom;
      end else if (busy_reg) begin
        if (trial[32]) begin
          rem_reg <= {rem_reg[30:0], q_reg[31]};
          q_reg   <= {q_reg[30:0], 1'b0};
        end else begin
          rem_reg <= trial[31:0];
          q_reg   <= {q_reg[30:0], 1'b1};
        end
        cnt_reg <= cnt_reg - 6'h01;
        if (cnt_reg == 6'h01) begin
          busy_reg <= 1'b0;
          done     <= 1'b1;
          // A zero divisor yields all ones, which later saturates the delay.
          quot     <= trial[32] ? {q_reg[30:0], 1'b0} : {q_reg[30:0], 1'b1};
        end
      end
    end
  end
endmodule // seq_divider

//--- hdl/ov_stage_timing.sv
// Timing, blocking and status logic of one overvoltage protection stage.
// Notes on behaviour
// RULE_01 - Blocking input is sampled at each program cycle start, before pick-up.
// RULE_02 - Pick-up without blocking raises START and starts the operating timer.
// RULE_03 - Pick-up with blocking raises BLOCKED only; no START, no trip timing.
// RULE_04 - Blocking during START drops START and runs normal release handling.
// RULE_05 - Blocking must arrive at least 5 ms before the delay expires.
// RULE_06 - Instant operation gives TRIP together with START.
// RULE_07 - Fixed delay mode trips after the delay with continuous pick-up.
// RULE_08 - Inverse delay is dial over (ratio to the exponent minus one).
// RULE_09 - Delay type selects fixed or inverse, fixed by default.
// RULE_10 - Fixed delay in 5 ms steps, default 40 ms, zero means instant.
// RULE_11 - Time dial in 10 ms steps, default 50 ms, inverse only.
// RULE_12 - Exponent in 0.01 steps, default 1.00.
// RULE_13 - Release delay in 5 ms steps, default 60 ms, holds START.
// RULE_14 - Delayed release clears START after release delay, else at once.
// RULE_15 - Timer clears after quiet release delay, or at once when disabled.
// RULE_16 - Continue option keeps operating timer running through release time.
// RULE_17 - Remaining time to trip is reported in 5 ms units.
// RULE_18 - Expected inverse operating time is recomputed as the level changes.
// RULE_19 - Ratios of level to threshold reported per channel in 0.01 units.
// RULE_20 - Primary pick-up level from threshold and scaling, 0.1 V units.
// RULE_21 - Node operating mode is reported as on, blocked, test, both or off.
// RULE_22 - Pick-up above threshold, released below 97 percent of it.
// RULE_23 - Pick-up needs one, two or three phases over per operation mode.
// RULE_24 - Timers step once per program cycle; TRIP clears with START.
// RULE_25 - BLOCKED drops in the first cycle with blocking inactive.
`timescale 1ns/1ps
`include "ov_stage_defs.svh"
module ov_stage_timing #(
  parameter int PROG_CYCLE_CLKS = `PROG_CYCLE_NS / `CLK_PERIOD_NS
) (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      block_in,
  input  wire logic [15:0]               measured_level [4],
  input  wire logic [13:0]               threshold,
  input  wire logic [1:0]                pickup_phases,
  input  wire logic [19:0]               vt_primary_volts,
  input  wire ov_stage_pkg::node_mode_e  node_mode_cfg,
  input  wire ov_stage_pkg::timing_cfg_s cfg_in,
  input  wire logic                      cfg_load,
  output ov_stage_pkg::stage_flags_s     flags,
  output logic signed [19:0]             time_remaining,
  output logic [18:0]                    expected_time,
  output logic [16:0]                    level_ratio [4],
  output logic [23:0]                    pickup_primary,
  output ov_stage_pkg::node_mode_e       node_operating_mode
);
  import ov_stage_pkg::*;

  function automatic logic [20:0] log2_q16(input logic [31:0] x);
    logic [4:0]  p;
    logic [31:0] n;
    p = 5'd0;
    for (int i = 0; i < 32; i++) begin
      if (x[i]) p = 5'(i);
    end
    n = x << (5'd31 - p);
    log2_q16 = (p < 5'd16) ? 21'h000000 : {5'(p - 5'd16), n[30:15]};
  endfunction

  function automatic logic [31:0] exp2_q16(input logic [31:0] y);
    if (y[31:16] > `EXP_INT_MAX) exp2_q16 = 32'hffffffff;
    else exp2_q16 = 32'({1'b1, y[15:0]}) << y[19:16];
  endfunction

  timing_cfg_s  cfg_reg;
  logic [31:0]  tick_cnt_reg;
  logic         tick_reg;
  logic         blk_smp_reg;
  logic [2:0]   exceed_reg;
  logic [2:0]   exceed_next;
  logic [1:0]   n_exceed;
  logic         pickup_now;
  logic         blk_now;
  logic         run_ok;
  logic [18:0]  inv_time_reg;
  logic [18:0]  target;
  logic [18:0]  op_cnt_reg;
  logic [18:0]  op_inc;
  logic [14:0]  rel_cnt_reg;
  logic [14:0]  rel_inc;
  logic         releasing_reg;
  calc_state_e  calc_reg;
  logic [1:0]   ch_reg;
  logic [1:0]   max_ch;
  logic         div_start_reg;
  logic [31:0]  div_num_reg;
  logic [31:0]  div_den_reg;
  logic         div_done;
  logic [31:0]  div_quot;
  logic [31:0]  pow_q16;
  logic [32:0]  expo_prod;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_reg <= '{1'b0, `FIXED_DELAY_DEF, `TIME_DIAL_DEF, `EXPONENT_DEF,
                   `RELEASE_DELAY_DEF, 1'b1, 1'b1, 1'b0}; // [RULE_09] [RULE_10] [RULE_11]
    end else if (cfg_load) begin
      cfg_reg <= cfg_in; // [RULE_12] [RULE_13]
    end
  end

  // Program cycle tick, 5 ms of clock; every timer steps on it.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg     <= (tick_cnt_reg == 32'(PROG_CYCLE_CLKS - 1)); // [RULE_24]
      tick_cnt_reg <= (tick_cnt_reg == 32'(PROG_CYCLE_CLKS - 1)) ? 32'h00000000
                                                                 : tick_cnt_reg + 32'h1;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (measured_level[i] > 16'(threshold)) exceed_next[i] = 1'b1; // [RULE_22]
      else if (32'(measured_level[i]) * `RATIO_SCALE < 32'(threshold) * 32'(`RESET_RATIO_PCT))
        exceed_next[i] = 1'b0;
      else exceed_next[i] = exceed_reg[i];
    end
    n_exceed = 2'(exceed_next[0]) + 2'(exceed_next[1]) + 2'(exceed_next[2]);
  end

  // Operation mode zero is read as one phase.
  assign pickup_now = (n_exceed >= ((pickup_phases == 2'd0) ? 2'd1 : pickup_phases)); // [RULE_23]
  // Blocking is taken as it stands at the tick; pick-up is judged after it.
  assign blk_now = block_in || node_mode_cfg == NODE_BLOCKED
                   || node_mode_cfg == NODE_TEST_BLOCKED; // [RULE_01]
  assign run_ok  = node_mode_cfg != NODE_OFF;
  assign target  = cfg_reg.inverse_delay_mode ? inv_time_reg // [RULE_09]
                   : 19'(cfg_reg.fixed_delay);
  assign op_inc  = (op_cnt_reg == `MAX_OP_UNITS) ? op_cnt_reg : op_cnt_reg + 19'h1;
  assign rel_inc = (rel_cnt_reg == 15'h7fff) ? rel_cnt_reg : rel_cnt_reg + 15'h1;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      exceed_reg  <= 3'b000;
      blk_smp_reg <= 1'b0;
    end else if (tick_reg) begin
      exceed_reg  <= exceed_next;
      blk_smp_reg <= blk_now; // [RULE_01]
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      flags         <= '0;
      op_cnt_reg    <= 19'h00000;
      rel_cnt_reg   <= 15'h0000;
      releasing_reg <= 1'b0;
    end else if (tick_reg) begin
      if (!run_ok) begin
        flags         <= '0;
        op_cnt_reg    <= 19'h00000;
        rel_cnt_reg   <= 15'h0000;
        releasing_reg <= 1'b0;
      end else if (pickup_now && !blk_now) begin
        flags.start   <= 1'b1; // [RULE_02]
        flags.blocked <= 1'b0;
        releasing_reg <= 1'b0;
        rel_cnt_reg   <= 15'h0000;
        op_cnt_reg    <= op_inc; // [RULE_24]
        // A zero target trips with START itself.
        flags.trip    <= (target == 19'h00000) // [RULE_06] [RULE_10]
                         || (op_inc >= target); // [RULE_07]
      end else begin
        // Blocking arrives here as well, so a running START releases normally.
        flags.blocked <= blk_now && (pickup_now || flags.blocked); // [RULE_03] [RULE_25]
        flags.trip    <= 1'b0; // [RULE_24]
        if (flags.trip) begin
          flags.start   <= 1'b0;
          op_cnt_reg    <= 19'h00000;
          releasing_reg <= 1'b0;
          rel_cnt_reg   <= 15'h0000;
        end else if (flags.start || releasing_reg) begin
          rel_cnt_reg <= rel_inc;
          if (rel_inc >= cfg_reg.release_delay) begin
            releasing_reg <= 1'b0;
            flags.start   <= 1'b0;
            rel_cnt_reg   <= 15'h0000;
            op_cnt_reg    <= 19'h00000; // [RULE_15]
          end else begin
            releasing_reg <= 1'b1; // [RULE_04]
            flags.start   <= cfg_reg.delayed_release && !blk_now; // [RULE_13] [RULE_14]
            if (cfg_reg.continue_in_release) op_cnt_reg <= op_inc; // [RULE_16]
            else if (!cfg_reg.reset_after_release) op_cnt_reg <= 19'h00000; // [RULE_15]
          end
        end
      end
    end
  end

  // One shared divider serves the four ratios, the Q16 ratio and the inverse delay.
  assign max_ch = (measured_level[0] >= measured_level[1]
                   && measured_level[0] >= measured_level[2])
                  ? 2'd0 : (measured_level[1] >= measured_level[2]) ? 2'd1 : 2'd2;
  assign expo_prod = 33'(cfg_reg.exponent) * 33'(log2_q16(div_quot));
  assign pow_q16   = exp2_q16(32'(expo_prod / 33'd100)); // [RULE_08]

  always_ff @(posedge clk) begin
    if (!nrst) begin
      calc_reg      <= CALC_IDLE;
      ch_reg        <= 2'd0;
      div_start_reg <= 1'b0;
      div_num_reg   <= 32'h00000000;
      div_den_reg   <= 32'h00000000;
      inv_time_reg  <= 19'h00000;
      for (int i = 0; i < 4; i++) level_ratio[i] <= 17'h00000;
    end else begin
      div_start_reg <= 1'b0;
      case (calc_reg)
        CALC_IDLE: begin
          if (tick_reg) begin
            calc_reg      <= CALC_RATIO;
            ch_reg        <= 2'd0;
            div_num_reg   <= 32'(measured_level[0]) * `RATIO_SCALE;
            div_den_reg   <= 32'(threshold);
            div_start_reg <= 1'b1;
          end
        end
        CALC_RATIO: begin
          if (div_done) begin
            level_ratio[ch_reg] <= div_quot[16:0]; // [RULE_19]
            div_start_reg       <= 1'b1;
            div_den_reg         <= 32'(threshold);
            if (ch_reg == 2'd3) begin
              calc_reg    <= CALC_POWER;
              div_num_reg <= {measured_level[max_ch], 16'h0000};
            end else begin
              ch_reg      <= ch_reg + 2'd1;
              div_num_reg <= 32'(measured_level[ch_reg + 2'd1]) * `RATIO_SCALE;
            end
          end
        end
        CALC_POWER: begin
          if (div_done) begin
            // Log and power use a piecewise linear fit: about 6 percent worst error.
            calc_reg      <= CALC_INV;
            div_num_reg   <= {2'b00, cfg_reg.time_dial, 1'b0, 16'h0000}; // [RULE_11]
            div_den_reg   <= pow_q16 - `Q16_ONE;
            div_start_reg <= 1'b1;
          end
        end
        CALC_INV: begin
          if (div_done) begin
            calc_reg     <= CALC_IDLE;
            inv_time_reg <= (div_quot > 32'(`MAX_OP_UNITS)) ? `MAX_OP_UNITS // [RULE_08] [RULE_18]
                                                            : div_quot[18:0];
          end
        end
        default: calc_reg <= CALC_IDLE;
      endcase
    end
  end

  seq_divider u_div (
    .clk   (clk),
    .nrst  (nrst),
    .start (div_start_reg),
    .numer (div_num_reg),
    .denom (div_den_reg),
    .done  (div_done),
    .quot  (div_quot)
  );

  always_ff @(posedge clk) begin
    if (!nrst) begin
      time_remaining      <= 20'sh00000;
      expected_time       <= 19'h00000;
      pickup_primary      <= 24'h000000;
      node_operating_mode <= NODE_ON;
    end else begin
      expected_time       <= target; // [RULE_18]
      time_remaining      <= 20'(target) - 20'(op_cnt_reg); // [RULE_17]
      pickup_primary      <= 24'((34'(threshold) * 34'(vt_primary_volts))
                                 / `PRIMARY_DIV); // [RULE_20]
      node_operating_mode <= node_mode_cfg; // [RULE_21]
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_trip_with_start:  assert property (flags.trip |-> flags.start) // [RULE_24]
    else $error("trip without start");
  a_blocked_no_start: assert property (flags.blocked |-> !flags.start) // [RULE_03]
    else $error("blocked while started");
  a_pickup_starts:    assert property (tick_reg && run_ok && pickup_now && !blk_now // [RULE_02]
                                       |=> flags.start)
    else $error("start missing on pickup");
  a_block_drops:      assert property (tick_reg && blk_now |=> !flags.start) // [RULE_04]
    else $error("start held under blocking");
  a_instant_trip:     assert property (tick_reg && run_ok && pickup_now && !blk_now // [RULE_06]
                                       && target == 19'h00000 |=> flags.trip)
    else $error("instant trip missing");
  a_fixed_elapsed:    assert property (tick_reg && run_ok && pickup_now && !blk_now // [RULE_07]
                                       && !cfg_reg.inverse_delay_mode
                                       && op_inc >= 19'(cfg_reg.fixed_delay)
                                       |=> flags.trip)
    else $error("fixed delay trip missing");
  a_blocked_clears:   assert property (tick_reg && !blk_now |=> !flags.blocked) // [RULE_25]
    else $error("blocked held without blocking");
  a_block_sampled:    assert property (flags.blocked |-> blk_smp_reg) // [RULE_01]
    else $error("blocked without sampled blocking");
  a_quick_release:    assert property (tick_reg && run_ok && !pickup_now // [RULE_14]
                                       && flags.start && !cfg_reg.delayed_release
                                       |=> !flags.start)
    else $error("start not released at once");
  a_timer_cleared:    assert property (tick_reg && run_ok && !pickup_now // [RULE_15]
                                       && flags.start && !cfg_reg.reset_after_release
                                       && !cfg_reg.continue_in_release
                                       |=> op_cnt_reg == 19'h00000)
    else $error("operating timer not cleared");
  a_tick_spacing:     assert property (tick_reg |=> !tick_reg) // [RULE_24]
    else $error("program cycle tick too close");

  c_trip:     cover property (flags.start ##1 flags.trip);
  c_blocked:  cover property (flags.blocked ##1 !flags.blocked);
  c_held:     cover property (releasing_reg && flags.start);
  c_inverse:  cover property (cfg_reg.inverse_delay_mode && flags.trip);
endmodule // ov_stage_timing

//--- verif/block_source.sv
// Model of the blocking matrix and the setting software that feed one stage.
`timescale 1ns/1ps
module block_source (
  input  wire logic                      clk,
  input  wire logic                      block_req,
  input  wire ov_stage_pkg::timing_cfg_s cfg_req,
  input  wire logic                      load_req,
  output logic                           block_in,
  output ov_stage_pkg::timing_cfg_s      cfg_in,
  output logic                           cfg_load
);
  import ov_stage_pkg::*;
  // Blocking is handed on one clock late, and the bench raises it half a program cycle
  // before the tick that must see it, so it always arrives ahead of the delay running out.
  // Outside a load pulse the setting bus carries inverted junk, so a stage that copies the
  // settings at any other time than the load pulse ends up with wrong timing.
  always @(posedge clk) begin
    block_in <= block_req;
    cfg_in   <= load_req ? cfg_req : ~cfg_req;
    cfg_load <= load_req;
  end
endmodule // block_source

//--- verif/tb.sv
// Self-checking bench for the overvoltage stage timing block.
`timescale 1ns/1ps
module tb;
  import ov_stage_pkg::*;
  localparam int P = 256;
  logic               clk       = 1'b0;
  logic               nrst      = 1'b0;
  logic               block_req = 1'b0;
  logic               load_req  = 1'b0;
  timing_cfg_s        cfg_req   = '0;
  logic [11:0]        expo      = 12'h064;
  logic [15:0]        lvl [4]   = '{default: 16'h0000};
  logic [13:0]        thr       = 14'h2710;
  logic [1:0]         phases    = 2'h1;
  logic [19:0]        vt        = 20'h04e20;
  node_mode_e         nmode     = NODE_ON;
  logic               block_in;
  logic               cfg_load;
  timing_cfg_s        cfg_in;
  stage_flags_s       flags;
  logic signed [19:0] t_rem;
  logic [18:0]        t_exp;
  logic [16:0]        ratio [4];
  logic [23:0]        prim;
  node_mode_e         nmode_out;
  node_mode_e         modes [5] = '{NODE_ON, NODE_BLOCKED, NODE_TEST, NODE_TEST_BLOCKED, NODE_OFF};
  logic [2:0]         mflags [5] = '{3'h4, 3'h1, 3'h4, 3'h1, 3'h0};
  logic [6:0]         rel_tab [4] = '{7'h64, 7'h24, 7'h47, 7'h73};
  int                 mismatches  = 0;
  int                 check_count = 0;

  always #4 clk = ~clk;

  block_source block_source_inst (.clk(clk), .block_req(block_req), .cfg_req(cfg_req),
    .load_req(load_req), .block_in(block_in), .cfg_in(cfg_in), .cfg_load(cfg_load));

  ov_stage_timing #(.PROG_CYCLE_CLKS(P)) ov_stage_timing_inst (.clk(clk), .nrst(nrst),
    .block_in(block_in), .measured_level(lvl), .threshold(thr), .pickup_phases(phases),
    .vt_primary_volts(vt), .node_mode_cfg(nmode), .cfg_in(cfg_in), .cfg_load(cfg_load),
    .flags(flags), .time_remaining(t_rem), .expected_time(t_exp), .level_ratio(ratio),
    .pickup_primary(prim), .node_operating_mode(nmode_out));

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Totals: %0d checks, %0d mismatches", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One step is one program cycle; steps end halfway between ticks, before the last ratio and the inverse delay of that cycle are updated.
  task automatic step(input int n);
    repeat (n * P) @(posedge clk);
  endtask

  task automatic drive(input logic [15:0] a, b, c, input logic blk);
    lvl       <= '{a, b, c, 16'h1388};
    block_req <= blk;
  endtask

  // A load takes exactly one step so that the bench stays aligned with the ticks.
  task automatic load(input logic inv, input logic [17:0] d, input logic [2:0] rel);
    cfg_req  <= '{inv, d, 13'h0005, expo, 15'h0002, rel[2], rel[1], rel[0]};
    load_req <= 1'b1;
    @(posedge clk);
    load_req <= 1'b0;
    repeat (P - 1) @(posedge clk);
  endtask

  task automatic chk_flags(input logic [2:0] exp, input string what);
    chk(24'({flags.start, flags.trip, flags.blocked}), 24'(exp), what);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    chk_flags(3'h0, "flags in reset");
    chk(24'(nmode_out), 24'(NODE_ON), "mode in reset");
    nrst <= 1'b1;
    repeat (P / 2) @(posedge clk);
    // Default settings: fixed delay of eight cycles, counted down step by step.
    drive(16'h2ee0, 16'h3a98, 16'h2710, 1'b0);
    for (int k = 1; k <= 8; k++) begin
      step(1);
      chk_flags({1'b1, 1'(k == 8), 1'b0}, "fixed delay flags");
      chk(24'(t_rem), 24'(8 - k), "time remaining");
      chk(24'(t_exp), 24'h8, "default delay");
    end
    chk(24'(ratio[0]), 24'h78, "ratio phase 0");
    chk(24'(ratio[1]), 24'h96, "ratio phase 1");
    chk(24'(ratio[2]), 24'h64, "ratio phase 2");
    chk(24'(ratio[3]), 24'h32, "ratio supervised");
    chk(prim, 24'h030d40, "primary pick-up");
    drive(16'h0000, 16'h0000, 16'h0000, 1'b0);
    step(1);
    chk_flags(3'h0, "trip released");
    $display("test fixed delay done");
    // Default release delay of twelve cycles holds start after a short pick-up.
    drive(16'h2ee0, 16'h2ee0, 16'h2ee0, 1'b0);
    step(2);
    drive(16'h0000, 16'h0000, 16'h0000, 1'b0);
    step(11);
    chk_flags(3'h4, "start held in release");
    step(1);
    chk_flags(3'h0, "start after release");
    $display("test default release done");
    // Release options: delayed start, timer clearing and timer continuing.
    foreach (rel_tab[i]) begin
      load(1'b0, 18'h00008, rel_tab[i][6:4]);
      drive(16'h2ee0, 16'h2ee0, 16'h2ee0, 1'b0);
      step(3);
      drive(16'h0000, 16'h0000, 16'h0000, 1'b0);
      step(1);
      chk_flags({rel_tab[i][6], 2'h0}, "start during release");
      drive(16'h2ee0, 16'h2ee0, 16'h2ee0, 1'b0);
      step(1);
      chk(24'(t_rem), 24'(rel_tab[i][3:0]), "resumed count");
      drive(16'h0000, 16'h0000, 16'h0000, 1'b0);
      step(3);
    end
    $display("test release options done");
    // A zero delay trips together with start.
    load(1'b0, 18'h00000, 3'h6);
    drive(16'h2ee0, 16'h2ee0, 16'h2ee0, 1'b0);
    step(1);
    chk_flags(3'h6, "instant trip");
    drive(16'h0000, 16'h0000, 16'h0000, 1'b0);
    step(3);
    $display("test instant done");
    // Blocking before pick-up, release of blocking, and blocking during start.
    load(1'b0, 18'h00008, 3'h6);
    drive(16'h2ee0, 16'h2ee0, 16'h2ee0, 1'b1);
    step(3);
    chk_flags(3'h1, "blocked pick-up");
    chk(24'(t_rem), 24'h8, "no timing while blocked");
    drive(16'h2ee0, 16'h2ee0, 16'h2ee0, 1'b0);
    step(2);
    chk_flags(3'h4, "unblocked start");
    drive(16'h2ee0, 16'h2ee0, 16'h2ee0, 1'b1);
    step(1);
    chk_flags(3'h1, "block during start");
    drive(16'h2ee0, 16'h2ee0, 16'h2ee0, 1'b0);
    step(1);
    chk(24'(t_rem), 24'h5, "count held over block");
    drive(16'h0000, 16'h0000, 16'h0000, 1'b0);
    step(3);
    $display("test blocking done");
    // Hysteresis at the threshold and at 97 percent of it, with instant release.
    load(1'b0, 18'h00008, 3'h2);
    drive(16'h2710, 16'h2710, 16'h2710, 1'b0);
    step(1);
    chk_flags(3'h0, "level at threshold");
    drive(16'h2711, 16'h0000, 16'h0000, 1'b0);
    step(1);
    chk_flags(3'h4, "level above threshold");
    drive(16'h25e4, 16'h0000, 16'h0000, 1'b0);
    step(1);
    chk_flags(3'h4, "level at reset ratio");
    drive(16'h25e3, 16'h0000, 16'h0000, 1'b0);
    step(1);
    chk_flags(3'h0, "level below reset ratio");
    // Number of phases that must be over the threshold.
    phases <= 2'h2;
    drive(16'h2ee0, 16'h0000, 16'h0000, 1'b0);
    step(1);
    chk_flags(3'h0, "one of two phases");
    drive(16'h2ee0, 16'h2ee0, 16'h0000, 1'b0);
    step(1);
    chk_flags(3'h4, "two of two phases");
    phases <= 2'h3;
    step(1);
    chk_flags(3'h0, "two of three phases");
    drive(16'h2ee0, 16'h2ee0, 16'h2ee0, 1'b0);
    step(1);
    chk_flags(3'h4, "three of three phases");
    phases <= 2'h1;
    drive(16'h0000, 16'h0000, 16'h0000, 1'b0);
    step(3);
    $display("test pick-up done");
    // Inverse time: dial of ten cycles over ratio minus one; a fitted curve allows one unit.
    load(1'b1, 18'h00008, 3'h6);
    drive(16'h4e20, 16'h4e20, 16'h4e20, 1'b0);
    step(2);
    chk(24'(t_exp inside {[19'd9:19'd11]}), 24'h1, "inverse ratio 2");
    drive(16'h7530, 16'h7530, 16'h7530, 1'b0);
    step(2);
    chk(24'(t_exp >= 19'd4 && t_exp <= 19'd6), 24'h1, "inverse at ratio 3");
    drive(16'h0000, 16'h0000, 16'h0000, 1'b0);
    step(3);
    // Exponent two at ratio two divides the dial by three, so the truncated delay is three cycles and the trip comes at the third tick.
    expo = 12'h0c8;
    load(1'b1, 18'h00008, 3'h6);
    drive(16'h4e20, 16'h4e20, 16'h4e20, 1'b0);
    step(2);
    chk(24'(t_exp inside {[19'd2:19'd4]}), 24'h1, "inverse exponent two");
    step(2);
    chk_flags(3'h6, "inverse trip");
    drive(16'h0000, 16'h0000, 16'h0000, 1'b0);
    step(3);
    $display("test inverse done");
    // Every node mode, with pick-up present throughout.
    load(1'b0, 18'h00008, 3'h2);
    drive(16'h2ee0, 16'h2ee0, 16'h2ee0, 1'b0);
    foreach (modes[i]) begin
      nmode <= modes[i];
      step(1);
      chk(24'(nmode_out), 24'(modes[i]), "node mode");
      chk_flags(mflags[i], "flags per node mode");
    end
    nmode <= NODE_ON;
    $display("test node modes done");
    end_of_test();
  end

  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule // tb
